/* verilog/dphy_timing_pkg.sv */
// ----------------------------------------------------------------
// timing override register bank constants
// ----------------------------------------------------------------
package dphy_timing_pkg;
    localparam int NUM_FIELDS = 6;            // six timing parameters
    localparam int REG_W = 8;                 // width of each register
    localparam int VALUE_W = 7;               // value field width
    localparam int FORCE_BIT = 7;             // override enable position
    localparam int VALUE_MSB = 6;             // top bit of the value field
    localparam int IDX_W = 8;                 // width of a register index
    localparam int IDX_SHIFT = 2;             // byte address is index times four
    localparam int SLOT_W = 3;                // width of a field slot number
    localparam int LANE_RATE_MBPS = 800;      // rate that the defaults belong to
    localparam logic FORCE_RST = 1'b0;        // override enable after reset

    // register indices, byte address is four times these
    localparam logic [IDX_W-1:0] IDX_CLK_ZERO = 8'h41;
    localparam logic [IDX_W-1:0] IDX_CLK_TRAIL = 8'h42;
    localparam logic [IDX_W-1:0] IDX_CLK_POST = 8'h43;
    localparam logic [IDX_W-1:0] IDX_LANE_PREPARE = 8'h44;
    localparam logic [IDX_W-1:0] IDX_LANE_ZERO = 8'h45;
    localparam logic [IDX_W-1:0] IDX_LANE_TRAIL = 8'h46;

    // value field defaults
    localparam logic [VALUE_W-1:0] RST_CLK_ZERO = 7'h1B;
    localparam logic [VALUE_W-1:0] RST_CLK_TRAIL = 7'h0B;
    localparam logic [VALUE_W-1:0] RST_CLK_POST = 7'h0A;
    localparam logic [VALUE_W-1:0] RST_LANE_PREPARE = 7'h06;
    localparam logic [VALUE_W-1:0] RST_LANE_ZERO = 7'h0C;
    localparam logic [VALUE_W-1:0] RST_LANE_TRAIL = 7'h08;

    localparam logic [31:0] RD_ZERO = 32'h0000_0000;  // unmapped read data
    localparam logic [1:0] WORD_ALIGNED = 2'h0;       // low address bits of a word

    // index lies inside the bank
    function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
        return (idx >= IDX_CLK_ZERO) && (idx <= IDX_LANE_TRAIL);
    endfunction : idx_mapped

    // index to field slot, only meaningful when mapped
    function automatic logic [SLOT_W-1:0] slot_of(input logic [IDX_W-1:0] idx);
        logic [IDX_W-1:0] diff;
        diff = idx - IDX_CLK_ZERO;
        return diff[SLOT_W-1:0];
    endfunction : slot_of

    // reset default of the value field of one slot
    function automatic logic [VALUE_W-1:0] default_of(input int slot);
        case (slot)
            0: return RST_CLK_ZERO;      // RULE_05
            1: return RST_CLK_TRAIL;     // RULE_06
            2: return RST_CLK_POST;      // RULE_07
            3: return RST_LANE_PREPARE;  // RULE_08
            4: return RST_LANE_ZERO;     // RULE_09
            default: return RST_LANE_TRAIL;  // RULE_10
        endcase
    endfunction : default_of
endpackage : dphy_timing_pkg

/* verilog/timing_field_if.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// carrier between the bank and one timing field
// ----------------------------------------------------------------
interface timing_field_if;
    import dphy_timing_pkg::*;
    logic wr_en;                      // one-cycle write strobe
    logic [REG_W-1:0] wr_data;        // byte written by software
    logic [VALUE_W-1:0] auto_value;   // value from the rate calculator
    logic [REG_W-1:0] rd_data;        // byte seen by software
    logic force_enable;               // override enable, a flop
    logic [VALUE_W-1:0] eff_value;    // value the transmitter should use
    modport bank (output wr_en, output wr_data, output auto_value,
                  input rd_data, input force_enable, input eff_value);
    modport field (input wr_en, input wr_data, input auto_value,
                   output rd_data, output force_enable, output eff_value);
endinterface : timing_field_if

/* verilog/timing_override_field.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// one timing register: override enable plus value
// ----------------------------------------------------------------
module timing_override_field
    import dphy_timing_pkg::*;
#(
    parameter logic [VALUE_W-1:0] RESET_VALUE = RST_CLK_ZERO  // value after reset
) (
    input wire logic clk,
    input wire logic resetn,
    timing_field_if.field port
);
    logic force_ff;                  // override enable
    logic nxt_force;
    logic [VALUE_W-1:0] value_ff;    // stored override value
    logic [VALUE_W-1:0] nxt_value;
    logic wr_force;                  // enable bit of the written byte
    logic [VALUE_W-1:0] shown_value; // value part of readback

    assign wr_force = port.wr_data[FORCE_BIT];
    // a write always sets or clears the enable
    assign nxt_force = port.wr_en ? wr_force : force_ff;  // RULE_01
    // value loads only with the enable set; while clear it tracks the
    // calculator, and the write that sets the enable also loads the value bits
    assign nxt_value = (port.wr_en && wr_force) ? port.wr_data[VALUE_MSB:0] :  // RULE_03
                       (!force_ff) ? port.auto_value : value_ff;  // RULE_02
    assign shown_value = force_ff ? value_ff : port.auto_value;  // RULE_02
    assign port.rd_data = {force_ff, shown_value};
    assign port.force_enable = force_ff;
    assign port.eff_value = shown_value;  // RULE_11

    // storage, defaults belong to the 800 Mbps lane rate
    always_ff @(posedge clk) begin
        if (!resetn) begin
            force_ff <= FORCE_RST;       // RULE_01
            value_ff <= RESET_VALUE;     // RULE_04
        end else begin
            force_ff <= nxt_force;
            value_ff <= nxt_value;
        end
    end

    sequence clear_write_s;
        port.wr_en && !port.wr_data[FORCE_BIT];
    endsequence
    sequence set_write_s;
        port.wr_en && port.wr_data[FORCE_BIT];
    endsequence

    AST_RESET_DEFAULT: assert property (@(posedge clk)  // RULE_04
        !resetn |=> !force_ff && value_ff == RESET_VALUE)
        else $error("field default wrong after reset");
    AST_CLEAR_WRITE_IGNORED: assert property (@(posedge clk) disable iff (!resetn)  // RULE_02
        clear_write_s |=> !force_ff && port.rd_data[VALUE_MSB:0] == port.auto_value)
        else $error("value write took effect with override clear");
    AST_SET_WRITE_TAKES: assert property (@(posedge clk) disable iff (!resetn)  // RULE_03
        set_write_s |=> force_ff && value_ff == $past(port.wr_data[VALUE_MSB:0]))
        else $error("override value not stored");
    AST_FORCED_HOLDS: assert property (@(posedge clk) disable iff (!resetn)  // RULE_03
        force_ff && !port.wr_en |=> $stable(value_ff) && force_ff)
        else $error("override value changed without a write");
    AST_EFF_SELECT: assert property (@(posedge clk) disable iff (!resetn)  // RULE_01
        port.eff_value == (force_ff ? value_ff : port.auto_value))
        else $error("effective value ignores override enable");
endmodule : timing_override_field

/* verilog/dphy_timing_bank.sv */
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// first output port D-PHY timing override bank, APB slave
// ----------------------------------------------------------------
// Contract
// RULE_01 - bit 7 enables override, resets clear
// RULE_02 - enable clear: value writes ignored, reads auto
// RULE_03 - enable set: value writable, replaces auto
// RULE_04 - defaults match 800 Mbps, auto recomputed
// RULE_05 - clock zero at 0x41, reset 0x1B
// RULE_06 - clock trail at 0x42, default 0xB
// RULE_07 - clock post at 0x43, default 0xA
// RULE_08 - lane prepare at 0x44, default 0x6
// RULE_09 - lane zero at 0x45, default 0xC
// RULE_10 - lane trail at 0x46, default 0x8
// RULE_11 - transmitter uses override or auto per enable
module dphy_timing_bank
    import dphy_timing_pkg::*;
#(
    parameter int ADDR_W = 12  // apb byte address width
) (
    input wire logic clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // automatically derived values from the rate calculator
    input wire logic [VALUE_W-1:0] auto_clk_zero_value,
    input wire logic [VALUE_W-1:0] auto_clk_trail_value,
    input wire logic [VALUE_W-1:0] auto_clk_post_value,
    input wire logic [VALUE_W-1:0] auto_lane_prepare_value,
    input wire logic [VALUE_W-1:0] auto_lane_zero_value,
    input wire logic [VALUE_W-1:0] auto_lane_trail_value,
    // values applied by the transmitter
    output logic [VALUE_W-1:0] clk_zero_value,
    output logic [VALUE_W-1:0] clk_trail_value,
    output logic [VALUE_W-1:0] clk_post_value,
    output logic [VALUE_W-1:0] lane_prepare_value,
    output logic [VALUE_W-1:0] lane_zero_value,
    output logic [VALUE_W-1:0] lane_trail_value,
    // override enables
    output logic clk_zero_force_enable,
    output logic clk_trail_force_enable,
    output logic clk_post_force_enable,
    output logic lane_prepare_force_enable,
    output logic lane_zero_force_enable,
    output logic lane_trail_force_enable
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // the highest byte address must fit the address bus
    if (ADDR_W < IDX_W + IDX_SHIFT) begin : g_bad_addr_w
        $error("ADDR_W too small for the register map");
    end

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic setup_phase;                 // first cycle of a transfer
    logic pready_ff;                   // access phase answer
    logic nxt_pready;
    logic access_done;                 // edge at which the transfer ends
    logic [IDX_W-1:0] req_index;       // word index from the address
    logic addr_aligned;                // low address bits are zero
    logic addr_hit;                    // address lies in the bank
    logic [SLOT_W-1:0] req_slot;       // field selected by the address
    logic wr_commit;                   // write takes effect this edge
    logic lane0_enabled;               // byte lane of the register written

    assign setup_phase = psel && !penable;
    // pready is only high in the access cycle, so this is one edge
    assign access_done = psel && penable && pready_ff;
    assign req_index = paddr[IDX_W+IDX_SHIFT-1:IDX_SHIFT];
    assign addr_aligned = (paddr[IDX_SHIFT-1:0] == WORD_ALIGNED);
    // bits above the index must be zero so no alias decodes
    assign addr_hit = addr_aligned && idx_mapped(req_index) &&
                      (paddr >> (IDX_W + IDX_SHIFT)) == '0;  // RULE_05
    assign req_slot = slot_of(req_index);  // RULE_05
    assign lane0_enabled = pstrb[0];
    // a write with lane 0 masked off stores nothing but still completes
    assign wr_commit = access_done && pwrite && addr_hit && lane0_enabled;

    // ----------------------------------------------------------------
    // bus response registers
    // ----------------------------------------------------------------
    logic pslverr_ff;                  // unmapped address answer
    logic nxt_pslverr;
    logic [31:0] prdata_ff;            // read data captured in setup
    logic [31:0] nxt_prdata;
    logic [REG_W-1:0] rd_byte [NUM_FIELDS];  // readback of each field
    logic [REG_W-1:0] sel_byte;        // readback of the addressed field

    assign sel_byte = rd_byte[req_slot];
    // answer one cycle after setup; the access phase never waits longer
    assign nxt_pready = setup_phase;
    // error for an unmapped or misaligned address, reads and writes alike
    assign nxt_pslverr = setup_phase && !addr_hit;
    // read data is captured at the end of setup; a calculator change in
    // the access cycle shows on the next read, a trade for a flopped bus
    assign nxt_prdata = (setup_phase && !pwrite && addr_hit) ?
                        {24'h00_0000, sel_byte} : RD_ZERO;  // RULE_02

    // bus response flops
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= RD_ZERO;
        end else begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata = prdata_ff;

    // ----------------------------------------------------------------
    // timing fields
    // ----------------------------------------------------------------
    logic [VALUE_W-1:0] auto_value [NUM_FIELDS];  // calculator values by slot
    logic [VALUE_W-1:0] eff_ff [NUM_FIELDS];      // applied values, flopped
    logic force_vec [NUM_FIELDS];                 // enables by slot

    // calculator inputs gathered by slot order
    assign auto_value[0] = auto_clk_zero_value;
    assign auto_value[1] = auto_clk_trail_value;
    assign auto_value[2] = auto_clk_post_value;
    assign auto_value[3] = auto_lane_prepare_value;
    assign auto_value[4] = auto_lane_zero_value;
    assign auto_value[5] = auto_lane_trail_value;

    timing_field_if field_if [NUM_FIELDS] ();

    for (genvar i = 0; i < NUM_FIELDS; i++) begin : g_field
        logic slot_hit;                // this field is addressed

        assign slot_hit = (req_slot == SLOT_W'(i));
        assign field_if[i].wr_en = wr_commit && slot_hit;
        assign field_if[i].wr_data = pwdata[REG_W-1:0];
        // the calculator recomputes these when the lane rate changes
        assign field_if[i].auto_value = auto_value[i];  // RULE_04
        assign rd_byte[i] = field_if[i].rd_data;
        assign force_vec[i] = field_if[i].force_enable;

        timing_override_field #(
            .RESET_VALUE(default_of(i))  // RULE_04
        ) u_field (
            .clk(clk),
            .resetn(resetn),
            .port(field_if[i])
        );

        // applied value, flopped so the transmitter sees a clean output
        always_ff @(posedge clk) begin
            if (!resetn) begin
                eff_ff[i] <= default_of(i);  // RULE_04
            end else begin
                eff_ff[i] <= field_if[i].eff_value;  // RULE_11
            end
        end

        AST_APPLIED_VALUE: assert property (@(posedge clk) disable iff (!resetn)  // RULE_11
            ##1 eff_ff[i] == $past(force_vec[i] ? rd_byte[i][VALUE_MSB:0] : auto_value[i]))
            else $error("applied value is not the selected one");
        AST_APPLIED_RESET: assert property (@(posedge clk)  // RULE_04
            !resetn |=> eff_ff[i] == default_of(i) && !force_vec[i])
            else $error("applied value not at default after reset");
    end

    // ----------------------------------------------------------------
    // transmitter side outputs
    // ----------------------------------------------------------------
    assign clk_zero_value = eff_ff[0];
    assign clk_trail_value = eff_ff[1];
    assign clk_post_value = eff_ff[2];
    assign lane_prepare_value = eff_ff[3];
    assign lane_zero_value = eff_ff[4];
    assign lane_trail_value = eff_ff[5];
    // enables come straight from the field flops
    assign clk_zero_force_enable = force_vec[0];
    assign clk_trail_force_enable = force_vec[1];
    assign clk_post_force_enable = force_vec[2];
    assign lane_prepare_force_enable = force_vec[3];
    assign lane_zero_force_enable = force_vec[4];
    assign lane_trail_force_enable = force_vec[5];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence read_setup_s;
        setup_phase && !pwrite && addr_hit;
    endsequence
    sequence write_to_s(logic [IDX_W-1:0] idx);
        access_done && pwrite && lane0_enabled && addr_aligned &&
        (paddr == ADDR_W'({idx, WORD_ALIGNED}));
    endsequence

    AST_ONE_WAIT: assert property (@(posedge clk) disable iff (!resetn)
        setup_phase |=> pready_ff ##1 !pready_ff)
        else $error("pready not a single cycle after setup");
    AST_UNMAPPED_ERR: assert property (@(posedge clk) disable iff (!resetn)
        setup_phase && !addr_hit |=> pslverr_ff && prdata_ff == RD_ZERO)
        else $error("unmapped access not refused");
    AST_READ_DATA: assert property (@(posedge clk) disable iff (!resetn)  // RULE_02
        read_setup_s |=> prdata_ff == {24'h00_0000, $past(sel_byte)} && !pslverr_ff)
        else $error("read data does not match the field");
    AST_CLK_ZERO_MAP: assert property (@(posedge clk) disable iff (!resetn)  // RULE_05
        write_to_s(IDX_CLK_ZERO) ##0 pwdata[FORCE_BIT] |=>
        clk_zero_force_enable ##1 clk_zero_value == $past(pwdata[VALUE_MSB:0], 2))
        else $error("clock zero register not at its index");
    AST_CLK_TRAIL_MAP: assert property (@(posedge clk) disable iff (!resetn)  // RULE_06
        write_to_s(IDX_CLK_TRAIL) |=> clk_trail_force_enable == $past(pwdata[FORCE_BIT]))
        else $error("clock trail register not at its index");
    AST_CLK_POST_MAP: assert property (@(posedge clk) disable iff (!resetn)  // RULE_07
        write_to_s(IDX_CLK_POST) |=> clk_post_force_enable == $past(pwdata[FORCE_BIT]))
        else $error("clock post register not at its index");
    AST_LANE_PREP_MAP: assert property (@(posedge clk) disable iff (!resetn)  // RULE_08
        write_to_s(IDX_LANE_PREPARE) |=> lane_prepare_force_enable == $past(pwdata[FORCE_BIT]))
        else $error("lane prepare register not at its index");
    AST_LANE_ZERO_MAP: assert property (@(posedge clk) disable iff (!resetn)  // RULE_09
        write_to_s(IDX_LANE_ZERO) |=> lane_zero_force_enable == $past(pwdata[FORCE_BIT]))
        else $error("lane zero register not at its index");
    AST_LANE_TRAIL_MAP: assert property (@(posedge clk) disable iff (!resetn)  // RULE_10
        write_to_s(IDX_LANE_TRAIL) |=> lane_trail_force_enable == $past(pwdata[FORCE_BIT]))
        else $error("lane trail register not at its index");
    AST_NO_STRAY_WRITE: assert property (@(posedge clk) disable iff (!resetn)  // RULE_01
        !wr_commit |=> $stable(clk_zero_force_enable) && $stable(lane_trail_force_enable))
        else $error("override enable changed without a write");
endmodule : dphy_timing_bank

/* sim/dphy_rate_calc_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// rate calculator stand-in: automatic timing per lane rate
// ----------------------------------------------------------------
module dphy_rate_calc_model
    import dphy_timing_pkg::*;
#(
    parameter logic [VALUE_W-1:0] ALT_STEP = 7'h05  // shift at the other rate
) (
    input wire logic rate_alt,
    output logic [NUM_FIELDS-1:0][VALUE_W-1:0] auto_v
);
    // base table belongs to the 800 Mbps rate
    localparam logic [NUM_FIELDS-1:0][VALUE_W-1:0] BASE = {RST_LANE_TRAIL, RST_LANE_ZERO,
        RST_LANE_PREPARE, RST_CLK_POST, RST_CLK_TRAIL, RST_CLK_ZERO};

    // any other rate moves every value, so stale defaults show up
    always_comb begin
        for (int i = 0; i < NUM_FIELDS; i++) begin
            auto_v[i] = BASE[i] + (rate_alt ? ALT_STEP : 7'h00);
        end
    end
endmodule : dphy_rate_calc_model

/* sim/dphy_timing_bank_tb.sv */
`timescale 1ns/1ps
module dphy_timing_bank_tb;
    import dphy_timing_pkg::*;
    // ----------------------------------------------------------------
    // signals and bookkeeping
    // ----------------------------------------------------------------
    typedef struct packed {logic [31:0] data; logic err;} note_t;  // one bus answer
    localparam logic [VALUE_W-1:0] STEP = 7'h05;  // same shift as the model
    localparam logic [NUM_FIELDS-1:0][VALUE_W-1:0] DEF = {RST_LANE_TRAIL, RST_LANE_ZERO,
        RST_LANE_PREPARE, RST_CLK_POST, RST_CLK_TRAIL, RST_CLK_ZERO};
    logic clk = 1'b0;
    logic resetn, psel, penable, pwrite, rate_alt;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    wire logic [31:0] prdata;
    wire logic pready, pslverr;
    wire logic [NUM_FIELDS-1:0][VALUE_W-1:0] auto_v, applied;
    wire logic [NUM_FIELDS-1:0] force_en;
    logic en_m [NUM_FIELDS];          // expected override enables
    logic [6:0] val_m [NUM_FIELDS];   // expected stored values
    note_t notes[$];                  // answers still owed by the bus
    int err_count = 0;
    int tests_run = 0;
    int seed = 78;
    int cycles = 0;
    logic [31:0] r;

    always #10 clk = ~clk;  // 50 MHz

    dphy_rate_calc_model u_dphy_rate_calc_model (.rate_alt(rate_alt), .auto_v(auto_v));

    dphy_timing_bank u_dphy_timing_bank (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .auto_clk_zero_value(auto_v[0]), .auto_clk_trail_value(auto_v[1]),
        .auto_clk_post_value(auto_v[2]), .auto_lane_prepare_value(auto_v[3]),
        .auto_lane_zero_value(auto_v[4]), .auto_lane_trail_value(auto_v[5]),
        .clk_zero_value(applied[0]), .clk_trail_value(applied[1]),
        .clk_post_value(applied[2]), .lane_prepare_value(applied[3]),
        .lane_zero_value(applied[4]), .lane_trail_value(applied[5]),
        .clk_zero_force_enable(force_en[0]), .clk_trail_force_enable(force_en[1]),
        .clk_post_force_enable(force_en[2]), .lane_prepare_force_enable(force_en[3]),
        .lane_zero_force_enable(force_en[4]), .lane_trail_force_enable(force_en[5]));

    // ----------------------------------------------------------------
    // reporting and comparison
    // ----------------------------------------------------------------
    task automatic fail(input string msg);
        err_count++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask : fail

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    task automatic cmp_bus(input note_t exp);
        tests_run++;
        if ({prdata, pslverr} !== exp) fail($sformatf("bus got %h exp %h", prdata, exp));
    endtask : cmp_bus

    task automatic cmp_val(input logic [7:0] act, input logic [7:0] exp);
        tests_run++;
        if (act !== exp) fail($sformatf("applied got %h exp %h", act, exp));
    endtask : cmp_val

    function automatic logic [6:0] exp_auto(input int i);
        return DEF[i] + (rate_alt ? STEP : 7'h00);
    endfunction : exp_auto

    // ----------------------------------------------------------------
    // apb master: entered just after an edge, leaves one idle cycle
    // ----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] wd,
                       input note_t exp);
        notes.push_back(exp);
        r = $random(seed);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {r[31:8], wd};  // upper bytes are noise the bank must ignore
        @(posedge clk);
        penable <= 1'b1;
        // wait as long as the slave needs; only the bench timeout ends it
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rd(input int i);
        apb(1'b0, 12'(IDX_CLK_ZERO + i) << IDX_SHIFT, 8'h00,
            note_t'{{24'h0, en_m[i], en_m[i] ? val_m[i] : exp_auto(i)}, 1'b0});
    endtask : rd

    task automatic wr(input int i, input logic [7:0] wd);
        apb(1'b1, 12'(IDX_CLK_ZERO + i) << IDX_SHIFT, wd, note_t'{RD_ZERO, 1'b0});
        if (pstrb[0]) begin
            en_m[i] = wd[7];
            if (wd[7]) val_m[i] = wd[6:0];
        end
    endtask : wr

    // applied outputs lag the selection by one flop
    task automatic check_applied(input string name);
        repeat (2) @(posedge clk);
        #1;
        for (int i = 0; i < NUM_FIELDS; i++) begin
            cmp_val({force_en[i], applied[i]}, {en_m[i], en_m[i] ? val_m[i] : exp_auto(i)});
        end
        $display("test %s done", name);
        // hand back on an edge so the next bus request starts right after it
        @(posedge clk);
    endtask : check_applied

    // ----------------------------------------------------------------
    // monitor: each completed transfer takes the oldest note
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            err_count++;
            finish_test();
        end else if (resetn && psel && penable && pready === 1'b1) begin
            if (notes.size() == 0) fail("unexpected transfer");
            else cmp_bus(notes.pop_front());
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        rate_alt = 1'b0;
        for (int i = 0; i < NUM_FIELDS; i++) begin
            en_m[i] = 1'b0;
            val_m[i] = 7'h00;
        end
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < NUM_FIELDS; i++) rd(i);
        check_applied("reset_values");
        // other rate: auto shown, value bits ignored while enable clear
        rate_alt <= 1'b1;
        for (int i = 0; i < NUM_FIELDS; i++) begin
            r = $random(seed);
            wr(i, {1'b0, r[6:0]});
            rd(i);
        end
        check_applied("auto_follow");
        // override every field with a random value
        for (int i = 0; i < NUM_FIELDS; i++) begin
            r = $random(seed);
            wr(i, {1'b1, r[6:0]});
            rd(i);
        end
        rate_alt <= 1'b0;
        check_applied("override");
        // write with byte lane 0 off stores nothing
        pstrb <= 4'hE;
        wr(2, 8'h80);
        pstrb <= 4'hF;
        rd(2);
        // clearing the enable hands control back to auto
        for (int i = 0; i < NUM_FIELDS; i++) begin
            wr(i, 8'h7F);
            rd(i);
        end
        check_applied("release");
        // addresses outside the bank or misaligned
        apb(1'b0, 12'h100, 8'h00, note_t'{RD_ZERO, 1'b1});
        apb(1'b1, 12'h11C, 8'hFF, note_t'{RD_ZERO, 1'b1});
        apb(1'b0, 12'h105, 8'h00, note_t'{RD_ZERO, 1'b1});
        rd(0);
        check_applied("unmapped");
        finish_test();
    end
endmodule : dphy_timing_bank_tb
